// ==== logic/bul_regs.svh ====
// bus timing and field constants for the unaligned/address-only/lock block
`ifndef BUL_REGS_SVH
`define BUL_REGS_SVH
`define BUL_CLK_NS          25
`define BUL_SETUP_NS        50
`define BUL_SETUP_CYC       ((`BUL_SETUP_NS + `BUL_CLK_NS - 1) / `BUL_CLK_NS)
`define BUL_ADO_HOLD_NS     100
`define BUL_ADO_HOLD_CYC    ((`BUL_ADO_HOLD_NS + `BUL_CLK_NS - 1) / `BUL_CLK_NS)
`define BUL_TIMEOUT_CYC     64
`define BUL_NRES            4
`define BUL_RES_LSB         16
`define BUL_LOCK_AM         6'h3a
`define BUL_ADDRESS_ONLY_HANDSHAKE_CYCLE_AM         6'h3b
`endif

// ==== logic/bul_pkg.sv ====
// types shared by both ends
package bul_pkg;
  // bytes marked by ds1/ds0/a1/lword as cycle width
  typedef enum logic [2:0] {
    BUL_W_NONE = 3'h0,
    BUL_W_B    = 3'h1,
    BUL_W_D    = 3'h2,
    BUL_W_MID  = 3'h3,
    BUL_W_TLO  = 3'h4,
    BUL_W_THI  = 3'h5,
    BUL_W_Q    = 3'h6
  } bul_width_type;
  typedef enum logic [1:0] {
    BUL_OP_XFER = 2'h0,
    BUL_OP_ADO  = 2'h1,
    BUL_OP_ADDRESS_ONLY_HANDSHAKE_CYCLE = 2'h2,
    BUL_OP_LOCK = 2'h3
  } bul_op_type;
  typedef enum logic [1:0] {
    BUL_R_DTACK = 2'h0,
    BUL_R_BERR  = 2'h1,
    BUL_R_RETRY = 2'h2,
    BUL_R_NONE  = 2'h3
  } bul_resp_type;
  // decode byte lanes from strobes, a1 and lword (strobes and lword active low here as levels, a1 high selects the upper lanes, or the middle pair with lword low)
  function automatic logic [3:0] bul_lanes(input logic ds1_n, input logic ds0_n,
                                           input logic a1, input logic lword_n);
    logic [3:0] l;
    l = 4'h0;
    unique case ({lword_n, a1, ds1_n, ds0_n})
      4'b1000: l = 4'h3;
      4'b1001: l = 4'h2;
      4'b1010: l = 4'h1;
      4'b1100: l = 4'hc;
      4'b1101: l = 4'h8;
      4'b1110: l = 4'h4;
      4'b0000: l = 4'hf;
      4'b0001: l = 4'he;
      4'b0010: l = 4'h7;
      4'b0100: l = 4'h6;
      default: l = 4'h0;
    endcase
    return l;
  endfunction : bul_lanes
endpackage : bul_pkg

// ==== logic/bul_bus_if.sv ====
// backplane bus carrier with master and slave modports
`timescale 1ns/10ps
`default_nettype none
interface bul_bus_if;
  logic [31:1] addr;
  logic [5:0]  am;
  logic        lword_n;
  logic        iack_n;
  logic        write_n;
  logic        as_n;
  logic        ds0_n;
  logic        ds1_n;
  logic        bbsy_n;
  logic [31:0] d_m_out;
  logic        d_m_oe_n;
  logic [31:0] d_s_out;
  logic        d_s_oe_n;
  logic        dtack_n_out;
  logic        dtack_oe_n;
  logic        berr_n_out;
  logic        berr_oe_n;
  logic        retry_n_out;
  logic        retry_oe_n;
  logic [31:0] data;
  logic        dtack_n;
  logic        berr_n;
  logic        retry_n;
  assign data    = !d_m_oe_n ? d_m_out : (!d_s_oe_n ? d_s_out : 32'hffffffff);
  assign dtack_n = dtack_oe_n | dtack_n_out;
  assign berr_n  = berr_oe_n | berr_n_out;
  assign retry_n = retry_oe_n | retry_n_out;
  modport master (output addr, am, lword_n, iack_n, write_n, as_n, ds0_n, ds1_n,
                  bbsy_n, d_m_out, d_m_oe_n, input data, dtack_n, berr_n, retry_n);
  modport slave (input addr, am, lword_n, iack_n, write_n, as_n, ds0_n, ds1_n,
                 bbsy_n, data, output d_s_out, d_s_oe_n, dtack_n_out, dtack_oe_n,
                 berr_n_out, berr_oe_n, retry_n_out, retry_oe_n);
endinterface : bul_bus_if
`default_nettype wire

// ==== logic/bul_sync3.sv ====
// three-flop synchroniser, change accepted when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module bul_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clock_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  input  wire logic [W-1:0] init_in,
  output var  logic [W-1:0] q_out
);
  logic [W-1:0] s1_r, s2_r, s3_r, q_r;
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        s1_r[i] <= 1'b1;
        s2_r[i] <= 1'b1;
        s3_r[i] <= 1'b1;
        q_r[i]  <= 1'b1;
      end else begin
        s1_r[i] <= d_in[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          q_r[i] <= s3_r[i];
        end
      end
    end
  end
  assign q_out = q_r;
endmodule : bul_sync3
`default_nettype wire

// ==== logic/bul_slave.sv ====
// slave end: unaligned transfers, address-only cycles and resource locks
`timescale 1ns/10ps
`default_nettype none
`include "bul_regs.svh"
// Summary of operation
// - triple bytes 1-3 then next byte 0
// - byte 3 then triple bytes 0-2
// - middle double byte on D23..8
// - unaligned only with 32-bit data path
// - incapable slave never acknowledges unaligned cycle
// - accept triple 0-2, 1-3, double 1-2
// - master drives address-only without strobes, no wait
// - slave gives no answer to address-only
// - handshaked address-only ends with dtack/berr/retry
// - handshaked address-only ignores write line
// - address-only never alters stored data
// - lock blocks other ports, addressed resource only
// - lock address phase handshaked, any width
// - locks held until as and bbsy high
// - record locked sequence, keep it indivisible
// - berr or retry ends mastership, unlocks
// - parked master releases bus after locks
// - retry lock when local port holds resource
// - master raises bbsy after last as rise
module bul_slave
  import bul_pkg::*;
(
  input  wire logic                    clock_in,
  input  wire logic                    rst_in,
  bul_bus_if.slave                     bus,
  input  wire logic                    uat_enable_in,
  input  wire logic [`BUL_NRES-1:0]    local_req_in,
  output var  logic [`BUL_NRES-1:0]    local_grant_out,
  output var  logic [`BUL_NRES-1:0]    bus_lock_out,
  output var  logic                    lock_seq_out,
  output var  logic [31:0]             mem_word_out
);
  // ==================================================================
  // input synchronisers
  // ==================================================================
  logic [4:0]  sy;
  logic        as_s;
  logic        ds0_s;
  logic        ds1_s;
  logic        bbsy_s;
  logic        write_s;

  // backplane strobes are not timed by this clock
  bul_sync3 #(.W(5)) u_sync (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .d_in     ({bus.as_n, bus.ds0_n, bus.ds1_n, bus.bbsy_n, bus.write_n}),
    .init_in  (5'h1f),
    .q_out    (sy)
  );
  assign as_s    = sy[4];
  assign ds0_s   = sy[3];
  assign ds1_s   = sy[2];
  assign bbsy_s  = sy[1];
  assign write_s = sy[0];

  // ==================================================================
  // state
  // ==================================================================
  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_ACK  = 2'h1,
    S_WAIT = 2'h2
  } bul_slv_st_type;

  typedef struct packed {
    bul_slv_st_type          st;
    logic [31:0]             mem;
    logic [`BUL_NRES-1:0]    bus_lock;
    logic [`BUL_NRES-1:0]    loc_lock;
    logic [`BUL_NRES-1:0]    grant;
    logic                    seq;
    logic [31:0]             dout;
    logic                    d_oe_n;
    logic                    dtack_oe_n;
    logic                    berr_oe_n;
    logic                    retry_oe_n;
  } bul_slv_type;
  bul_slv_type s_r, s_nxt;

  // ==================================================================
  // byte lane and command decode
  // ==================================================================
  logic [3:0]                 lanes;
  logic [1:0]                 res;
  logic                       lock_cmd;
  logic                       address_only_handshake_cycle_cmd;
  logic                       held;
  logic                       unal;
  assign lanes    = bul_lanes(ds1_s, ds0_s, bus.addr[1], bus.lword_n);
  assign res      = bus.addr[`BUL_RES_LSB +: 2];
  assign lock_cmd = (bus.am == `BUL_LOCK_AM);
  assign address_only_handshake_cycle_cmd = (bus.am == `BUL_ADDRESS_ONLY_HANDSHAKE_CYCLE_AM);
  assign held     = s_r.loc_lock[res];
  assign unal     = (lanes == 4'h7) ||
                    (lanes == 4'he) ||
                    (lanes == 4'h6);

  // ==================================================================
  // cycle handling
  // ==================================================================
  always_comb begin
    s_nxt = s_r;

    // local ports take free resources not held by the bus
    for (int i = 0; i < `BUL_NRES; i++) begin
      s_nxt.grant[i]    = local_req_in[i] && !s_r.bus_lock[i];
      s_nxt.loc_lock[i] = local_req_in[i] && (s_r.loc_lock[i] || !s_r.bus_lock[i]);
    end

    unique case (s_r.st)
      S_IDLE: begin
        // address-only without strobes: no decode effect, no answer
        if (!as_s && (!ds0_s || !ds1_s)) begin
          s_nxt.st = S_ACK;
          if (lock_cmd) begin
            // a local owner keeps the resource: retry
            if (held) begin
              s_nxt.retry_oe_n = 1'b0;
            end else begin
              s_nxt.bus_lock[res] = 1'b1;
              s_nxt.seq           = 1'b1;
              s_nxt.dtack_oe_n    = 1'b0;
            end
          end else if (s_r.seq == 1'b0 && held) begin
            s_nxt.retry_oe_n = 1'b0;
          end else if (address_only_handshake_cycle_cmd) begin
            // answered, but nothing stored or driven
            s_nxt.dtack_oe_n = 1'b0;
          end else if (unal && !uat_enable_in) begin
            // incapable: stay silent, master times out
            s_nxt.st = S_WAIT;
          end else if (lanes == 4'h0) begin
            s_nxt.berr_oe_n = 1'b0;
          end else begin
            // data lanes: triple/middle cycles use the lanes decoded from strobes, a1 and lword
            for (int b = 0; b < 4; b++) begin
              if (lanes[b] && !write_s) begin
                s_nxt.mem[b*8 +: 8] = bus.data[b*8 +: 8];
              end
            end
            s_nxt.dout       = s_r.mem;
            s_nxt.d_oe_n     = !write_s;
            s_nxt.dtack_oe_n = 1'b0;
          end
        end
      end
      S_ACK, S_WAIT: begin
        // answer stands until both strobes are seen high
        if (ds0_s && ds1_s) begin
          s_nxt.st         = S_IDLE;
          s_nxt.d_oe_n     = 1'b1;
          s_nxt.dtack_oe_n = 1'b1;
          s_nxt.berr_oe_n  = 1'b1;
          s_nxt.retry_oe_n = 1'b1;
        end
      end
      default: s_nxt.st = S_IDLE;
    endcase

    // mastership ends with as and bbsy high; berr/retry end it too
    if ((as_s && bbsy_s) || !s_r.berr_oe_n || !s_r.retry_oe_n) begin
      s_nxt.bus_lock = '0;
      s_nxt.seq      = 1'b0;
    end
  end

  // ==================================================================
  // state register and outputs
  // ==================================================================
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '{st:         S_IDLE,
               mem:        32'h0,
               bus_lock:   '0,
               loc_lock:   '0,
               grant:      '0,
               seq:        1'b0,
               dout:       32'h0,
               d_oe_n:     1'b1,
               dtack_oe_n: 1'b1,
               berr_oe_n:  1'b1,
               retry_oe_n: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.d_s_out     = s_r.dout;
  assign bus.d_s_oe_n    = s_r.d_oe_n;
  assign bus.dtack_n_out = 1'b0;
  assign bus.dtack_oe_n  = s_r.dtack_oe_n;
  assign bus.berr_n_out  = 1'b0;
  assign bus.berr_oe_n   = s_r.berr_oe_n;
  assign bus.retry_n_out = 1'b0;
  assign bus.retry_oe_n  = s_r.retry_oe_n;
  assign local_grant_out = s_r.grant;
  assign bus_lock_out    = s_r.bus_lock;
  assign lock_seq_out    = s_r.seq;
  assign mem_word_out    = s_r.mem;
endmodule : bul_slave
`default_nettype wire

// ==== logic/bul_master.sv ====
// master end: issues transfers, address-only and lock cycles
`timescale 1ns/10ps
`default_nettype none
`include "bul_regs.svh"
module bul_master
  import bul_pkg::*;
(
  input  wire logic          clock_in,
  input  wire logic          rst_in,
  bul_bus_if.master          bus,
  input  wire logic          req_in,
  input  wire bul_op_type    op_in,
  input  wire bul_width_type width_in,
  input  wire logic [31:1]   addr_in,
  input  wire logic          write_in,
  input  wire logic [31:0]   wdata_in,
  input  wire logic          release_in,
  output var  logic          busy_out,
  output var  logic          done_out,
  output var  bul_resp_type  resp_out,
  output var  logic [31:0]   rdata_out
);
  logic [2:0] sy;
  logic       dtack_s, berr_s, retry_s;
  bul_sync3 #(.W(3)) u_sync (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .d_in     ({bus.dtack_n, bus.berr_n, bus.retry_n}),
    .init_in  (3'h7),
    .q_out    (sy)
  );
  assign {dtack_s, berr_s, retry_s} = sy;

  // ==================================================================
  // state
  // ==================================================================
  typedef enum logic [2:0] {
    M_IDLE  = 3'h0,
    M_SETUP = 3'h1,
    M_STRB  = 3'h2,
    M_HOLD  = 3'h3,
    M_END   = 3'h4,
    M_REL   = 3'h5
  } bul_mst_st_type;
  typedef struct packed {
    bul_mst_st_type st;
    logic [7:0]   cnt;
    bul_op_type   op;
    logic         locked;
    logic [31:1]  addr;
    logic [5:0]   am;
    logic         lword_n;
    logic         write_n;
    logic         as_n;
    logic         ds0_n;
    logic         ds1_n;
    logic         ds0_pend_n;
    logic         ds1_pend_n;
    logic         bbsy_n;
    logic [31:0]  dout;
    logic         d_oe_n;
    logic         busy;
    logic         done;
    bul_resp_type resp;
    logic [31:0]  rdata;
  } bul_mst_type;
  bul_mst_type m_r, m_nxt;

  always_comb begin
    m_nxt      = m_r;
    m_nxt.done = 1'b0;
    unique case (m_r.st)
      M_IDLE: begin
        if (req_in) begin
          m_nxt.st      = M_SETUP;
          m_nxt.busy    = 1'b1;
          m_nxt.op      = op_in;
          m_nxt.bbsy_n  = 1'b0;
          m_nxt.addr    = addr_in;
          m_nxt.am      = (op_in == BUL_OP_LOCK) ? `BUL_LOCK_AM :
                          (op_in == BUL_OP_ADDRESS_ONLY_HANDSHAKE_CYCLE) ? `BUL_ADDRESS_ONLY_HANDSHAKE_CYCLE_AM : 6'h09;
          m_nxt.write_n = !write_in;
          m_nxt.dout    = wdata_in;
          m_nxt.cnt     = 8'(`BUL_SETUP_CYC);
          // byte lanes for each width (a1, lword, ds1, ds0)
          unique case (width_in)
            BUL_W_Q:   {m_nxt.lword_n, m_nxt.addr[1]} = 2'b00;
            BUL_W_TLO: {m_nxt.lword_n, m_nxt.addr[1]} = 2'b00;
            BUL_W_THI: {m_nxt.lword_n, m_nxt.addr[1]} = 2'b00;
            BUL_W_MID: {m_nxt.lword_n, m_nxt.addr[1]} = 2'b01;
            default:   m_nxt.lword_n = 1'b1;
          endcase
          // strobes wait for the end of setup; single bytes use the even lane
          m_nxt.ds1_pend_n = (width_in == BUL_W_TLO);
          m_nxt.ds0_pend_n = (width_in == BUL_W_THI) || (width_in == BUL_W_B);
        end else if (release_in || m_r.locked) begin
          m_nxt.bbsy_n = 1'b1;
          m_nxt.locked = 1'b0;
        end
      end
      M_SETUP: begin
        m_nxt.as_n = 1'b0;
        m_nxt.cnt  = m_r.cnt - 8'h1;
        if (m_r.cnt == 8'h1) begin
          if (m_r.op == BUL_OP_ADO) begin
            m_nxt.st  = M_HOLD;
            m_nxt.cnt = 8'(`BUL_ADO_HOLD_CYC);
          end else begin
            m_nxt.st     = M_STRB;
            m_nxt.ds0_n  = m_r.ds0_pend_n;
            m_nxt.ds1_n  = m_r.ds1_pend_n;
            m_nxt.d_oe_n = m_r.write_n || m_r.op != BUL_OP_XFER;
            m_nxt.cnt    = 8'(`BUL_TIMEOUT_CYC);
          end
          if (m_r.op != BUL_OP_XFER) begin
            m_nxt.ds0_n = m_r.op == BUL_OP_ADO;
            m_nxt.ds1_n = m_r.op == BUL_OP_ADO;
          end
        end
      end
      M_HOLD: begin
        m_nxt.cnt = m_r.cnt - 8'h1;
        if (m_r.cnt == 8'h1) begin
          m_nxt.st   = M_END;
          m_nxt.resp = BUL_R_NONE;
        end
      end
      M_STRB: begin
        m_nxt.cnt = m_r.cnt - 8'h1;
        if (!dtack_s || !berr_s || !retry_s || m_r.cnt == 8'h1) begin
          m_nxt.st    = M_END;
          m_nxt.rdata = bus.data;
          m_nxt.resp  = !dtack_s ? BUL_R_DTACK : (!retry_s ? BUL_R_RETRY : BUL_R_BERR);
          if (!dtack_s && m_r.op == BUL_OP_LOCK) begin
            m_nxt.locked = 1'b1;
          end
        end
      end
      M_END: begin
        m_nxt.as_n   = 1'b1;
        m_nxt.ds0_n  = 1'b1;
        m_nxt.ds1_n  = 1'b1;
        m_nxt.d_oe_n = 1'b1;
        m_nxt.st     = M_REL;
      end
      M_REL: begin
        if (dtack_s && berr_s && retry_s) begin
          m_nxt.st   = M_IDLE;
          m_nxt.busy = 1'b0;
          m_nxt.done = 1'b1;
          if (m_r.resp == BUL_R_BERR || m_r.resp == BUL_R_RETRY) begin
            m_nxt.bbsy_n = 1'b1;
            m_nxt.locked = 1'b0;
          end
        end
      end
      default: m_nxt.st = M_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      m_r <= '{st: M_IDLE, cnt: 8'h0, op: BUL_OP_XFER, locked: 1'b0, addr: 31'h0,
               am: 6'h0, lword_n: 1'b1, write_n: 1'b1, as_n: 1'b1, ds0_n: 1'b1,
               ds1_n: 1'b1, ds0_pend_n: 1'b1, ds1_pend_n: 1'b1, bbsy_n: 1'b1,
               dout: 32'h0, d_oe_n: 1'b1, busy: 1'b0,
               done: 1'b0, resp: BUL_R_NONE, rdata: 32'h0};
    end else begin
      m_r <= m_nxt;
    end
  end

  assign bus.addr     = m_r.addr;
  assign bus.am       = m_r.am;
  assign bus.lword_n  = m_r.lword_n;
  assign bus.iack_n   = 1'b1;
  assign bus.write_n  = m_r.write_n;
  assign bus.as_n     = m_r.as_n;
  assign bus.ds0_n    = m_r.ds0_n;
  assign bus.ds1_n    = m_r.ds1_n;
  assign bus.bbsy_n   = m_r.bbsy_n;
  assign bus.d_m_out  = m_r.dout;
  assign bus.d_m_oe_n = m_r.d_oe_n;
  assign busy_out     = m_r.busy;
  assign done_out     = m_r.done;
  assign resp_out     = m_r.resp;
  assign rdata_out    = m_r.rdata;
endmodule : bul_master
`default_nettype wire

// ==== bench/bul_bus_monitor.sv ====
// concurrent checks on the bus between the master and slave ends
`timescale 1ns/10ps
`default_nettype none
module bul_bus_monitor (
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic [31:1] addr,
  input wire logic        as_n,
  input wire logic        ds0_n,
  input wire logic        ds1_n,
  input wire logic        bbsy_n,
  input wire logic        dtack_n,
  input wire logic        berr_n,
  input wire logic        retry_n
);
  localparam int CYCLE_MAX = 120;
  default clocking mon_cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  // ==========================================================================
  // sequences
  sequence s_ado_stuck;
    (!as_n && ds0_n && ds1_n) [*8];
  endsequence
  property p_cycle_ends;
    $fell(as_n) |-> ##[1:CYCLE_MAX] as_n;
  endproperty
  // ==========================================================================
  // assertions
  a_answer_needs_strobe: assert property (
    $fell(dtack_n) || $fell(berr_n) || $fell(retry_n) |-> !as_n && !(ds0_n && ds1_n))
    else $error("answer without a data strobe");
  a_answer_one_line: assert property ($onehot0({!dtack_n, !berr_n, !retry_n}))
    else $error("more than one answer line low");
  a_answer_holds_low: assert property (
    !dtack_n && !(ds0_n && ds1_n) |=> !dtack_n)
    else $error("acknowledge released while strobe low");
  a_strobe_inside_as: assert property (!(ds0_n && ds1_n) |-> !as_n)
    else $error("data strobe low outside address strobe");
  a_addr_stable_as: assert property (!as_n && !$past(as_n) |-> $stable(addr))
    else $error("address moved while address strobe low");
  a_ado_not_stuck: assert property (s_ado_stuck |=> as_n || !(ds0_n && ds1_n))
    else $error("address-only cycle never ended");
  a_ado_min_hold: assert property (
    $rose(as_n) && $past(ds0_n) && $past(ds1_n) |-> !$past(as_n, 2) && !$past(as_n, 3))
    else $error("address-only cycle held too short");
  a_cycle_bounded: assert property (p_cycle_ends)
    else $error("bus cycle did not end in time");
  a_bbsy_after_as: assert property ($rose(bbsy_n) |-> as_n && $past(as_n))
    else $error("bus busy released before address strobe rose");
  c_ado_seen: cover property ($rose(as_n) && $past(ds0_n) && $past(ds1_n));
endmodule : bul_bus_monitor
`default_nettype wire

// ==== bench/bus_unaligned_addronly_lock_tb_top.sv ====
// self-checking bench joining master and slave ends over the bus carrier
`timescale 1ns/10ps
`default_nettype none
`include "bul_regs.svh"
module bus_unaligned_addronly_lock_tb_top
  import bul_pkg::*;
();
  logic                 clock_in;
  logic                 rst_in;
  logic                 req_in;
  bul_op_type           op_in;
  bul_width_type        width_in;
  logic [31:1]          addr_in;
  logic                 write_in;
  logic [31:0]          wdata_in;
  logic                 release_in;
  logic                 busy_out;
  logic                 done_out;
  bul_resp_type         resp_out;
  logic [31:0]          rdata_out;
  logic                 uat_enable_in;
  logic [`BUL_NRES-1:0] local_req_in;
  logic [`BUL_NRES-1:0] local_grant_out;
  logic [`BUL_NRES-1:0] bus_lock_out;
  logic                 lock_seq_out;
  logic [31:0]          mem_word_out;
  int                   n_fail;
  int                   samples_checked;
  int                   n_dtack;
  int                   k;
  logic                 dtack_q;
  logic [31:0]          ack_data;
  logic                 ack_lword_n;
  bul_resp_type         rsp;
  logic [31:0]          rd;
  logic [31:0]          exp;
  bul_width_type        wl[3] = '{BUL_W_TLO, BUL_W_THI, BUL_W_MID};
  logic [31:0]          ml[3] = '{32'h00ffffff, 32'hffffff00, 32'h00ffff00};
  logic                 al[3] = '{1'b0, 1'b0, 1'b1};
  // ==========================================================================
  // design and monitor
  bul_bus_if bul_bus_if_inst ();
  bul_slave bul_slave_inst (.clock_in(clock_in), .rst_in(rst_in), .bus(bul_bus_if_inst),
    .uat_enable_in(uat_enable_in), .local_req_in(local_req_in),
    .local_grant_out(local_grant_out), .bus_lock_out(bus_lock_out),
    .lock_seq_out(lock_seq_out), .mem_word_out(mem_word_out));
  bul_master bul_master_inst (.clock_in(clock_in), .rst_in(rst_in), .bus(bul_bus_if_inst),
    .req_in(req_in), .op_in(op_in), .width_in(width_in), .addr_in(addr_in),
    .write_in(write_in), .wdata_in(wdata_in), .release_in(release_in),
    .busy_out(busy_out), .done_out(done_out), .resp_out(resp_out), .rdata_out(rdata_out));
  bul_bus_monitor bul_bus_monitor_inst (.clock_in(clock_in), .rst_in(rst_in),
    .addr(bul_bus_if_inst.addr), .as_n(bul_bus_if_inst.as_n),
    .ds0_n(bul_bus_if_inst.ds0_n), .ds1_n(bul_bus_if_inst.ds1_n),
    .bbsy_n(bul_bus_if_inst.bbsy_n), .dtack_n(bul_bus_if_inst.dtack_n),
    .berr_n(bul_bus_if_inst.berr_n), .retry_n(bul_bus_if_inst.retry_n));
  // ==========================================================================
  // clock and wire watch
  initial clock_in = 1'b0;
  always #12.5 clock_in = ~clock_in;
  // counts acknowledge falls, keeps data lines seen at each
  always @(negedge clock_in) begin
    if (dtack_q && bul_bus_if_inst.dtack_n === 1'b0) begin
      n_dtack++;
      ack_data = bul_bus_if_inst.data;
      ack_lword_n = bul_bus_if_inst.lword_n;
    end
    dtack_q = bul_bus_if_inst.dtack_n;
  end
  // ==========================================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, want);
    end
  endtask : check
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  function automatic logic [31:1] res_addr(input logic [1:0] res, input logic a1);
    return {14'h0, res, 14'h0, a1};
  endfunction : res_addr
  task automatic run_op(input bul_op_type op, input bul_width_type w, input logic [31:1] a,
                        input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock_in);
    #2;
    op_in = op;
    width_in = w;
    addr_in = a;
    write_in = wr;
    wdata_in = wd;
    req_in = 1'b1;
    @(posedge clock_in);
    #2;
    req_in = 1'b0;
    do begin
      @(posedge clock_in);
      #1;
      n++;
    end while (done_out !== 1'b1 && n < 300);
    if (n >= 300) begin
      n_fail++;
      $display("[FAIL] %0t operation never completed", $time);
    end
    rsp = resp_out;
    rd = rdata_out;
    #1;
  endtask : run_op
  // ==========================================================================
  // watchdog and main sequence
  initial begin
    repeat (6000) @(posedge clock_in);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end
  initial begin
    rst_in = 1'b1;
    req_in = 1'b0;
    op_in = BUL_OP_XFER;
    width_in = BUL_W_Q;
    addr_in = '0;
    write_in = 1'b0;
    wdata_in = '0;
    release_in = 1'b0;
    uat_enable_in = 1'b1;
    local_req_in = '0;
    n_fail = 0;
    samples_checked = 0;
    n_dtack = 0;
    dtack_q = 1'b1;
    repeat (10) @(posedge clock_in);
    #2;
    rst_in = 1'b0;
    check(32'(bus_lock_out), 32'h0, "locks after reset");
    check(32'({busy_out, lock_seq_out}), 32'h0, "idle after reset");
    // unaligned writes and reads on the matching lanes
    for (int i = 0; i < 3; i++) begin
      run_op(BUL_OP_XFER, BUL_W_Q, res_addr(2'h0, 1'b0), 1'b1, 32'h11223344);
      run_op(BUL_OP_XFER, wl[i], res_addr(2'h0, al[i]), 1'b1, 32'haabbccdd);
      check(32'(rsp), 32'(BUL_R_DTACK), "unaligned write answer");
      check(ack_data & ml[i], 32'haabbccdd & ml[i], "write lanes");
      check(32'(ack_lword_n), 32'h0, "full path marker");
      exp = (32'h11223344 & ~ml[i]) | (32'haabbccdd & ml[i]);
      check(mem_word_out, exp, "unaligned write store");
      run_op(BUL_OP_XFER, wl[i], res_addr(2'h0, al[i]), 1'b0, 32'h0);
      check(32'(rsp), 32'(BUL_R_DTACK), "unaligned read answer");
      check(rd & ml[i], exp & ml[i], "unaligned read data");
    end
    // incapable slave stays silent on a triple-byte cycle
    run_op(BUL_OP_XFER, BUL_W_Q, res_addr(2'h0, 1'b0), 1'b1, 32'h55667788);
    uat_enable_in = 1'b0;
    k = n_dtack;
    run_op(BUL_OP_XFER, BUL_W_TLO, res_addr(2'h0, 1'b0), 1'b1, 32'haabbccdd);
    check(32'(n_dtack - k), 32'h0, "acknowledge on refused cycle");
    check(32'(rsp), 32'(BUL_R_BERR), "refused cycle answer");
    check(mem_word_out, 32'h55667788, "store after refusal");
    uat_enable_in = 1'b1;
    // address-only cycles leave the store alone
    k = n_dtack;
    run_op(BUL_OP_ADO, BUL_W_Q, res_addr(2'h1, 1'b0), 1'b1, 32'hdeadbeef);
    check(32'(n_dtack - k), 32'h0, "acknowledge on address-only");
    check(32'(rsp), 32'(BUL_R_NONE), "address-only answer");
    check(mem_word_out, 32'h55667788, "store after address-only");
    check(32'(bus_lock_out), 32'h0, "locks after address-only");
    for (int w = 0; w < 2; w++) begin
      run_op(BUL_OP_ADDRESS_ONLY_HANDSHAKE_CYCLE, BUL_W_Q, res_addr(2'h1, 1'b0), 1'(w), 32'h0);
      check(32'(rsp), 32'(BUL_R_DTACK), "handshaked address-only answer");
      check(mem_word_out, 32'h55667788, "store after handshake");
    end
    // lock one resource while another is held locally
    local_req_in = 4'b0001;
    run_op(BUL_OP_LOCK, BUL_W_Q, res_addr(2'h2, 1'b0), 1'b0, 32'h0);
    check(32'(rsp), 32'(BUL_R_DTACK), "lock answer");
    check(32'(bus_lock_out), 32'h4, "addressed resource locked");
    check(32'(lock_seq_out), 32'h1, "locked sequence recorded");
    check(32'(local_grant_out), 32'h1, "other resource still granted");
    release_in = 1'b1;
    k = 0;
    while (bul_bus_if_inst.bbsy_n !== 1'b1 && k < 100) begin
      @(posedge clock_in);
      #1;
      k++;
    end
    check(32'(bul_bus_if_inst.bbsy_n), 32'h1, "bus given up after lock");
    repeat (8) @(posedge clock_in);
    #1;
    check(32'(bus_lock_out), 32'h0, "locks cleared at end of mastership");
    check(32'(lock_seq_out), 32'h0, "locked sequence ended");
    release_in = 1'b0;
    // lock on a locally held resource is retried
    run_op(BUL_OP_LOCK, BUL_W_Q, res_addr(2'h0, 1'b0), 1'b0, 32'h0);
    check(32'(rsp), 32'(BUL_R_RETRY), "lock on held resource");
    check(32'(bul_bus_if_inst.bbsy_n), 32'h1, "mastership ended by retry");
    repeat (8) @(posedge clock_in);
    #1;
    check(32'(bus_lock_out), 32'h0, "no lock after retry");
    local_req_in = 4'b0000;
    stop_test();
  end
endmodule : bus_unaligned_addronly_lock_tb_top
`default_nettype wire
